// ---- rss_pkg.sv ----
package rss_pkg;

    // Register byte addresses.
    localparam logic [7:0] RSS_BACKUP_OFS = 8'h24;
    localparam logic [7:0] RSS_SWITCH_OFS = 8'h25;
    localparam logic [7:0] RSS_OUTPUT_OFS = 8'h26;
    localparam logic [7:0] RSS_UNLOCK_OFS = 8'h27;
    localparam logic [7:0] RSS_STATUS_OFS = 8'h28;
    localparam logic [7:0] RSS_BACKUP_RST = 8'h12;
    localparam logic [7:0] RSS_SWITCH_RST = 8'h63;
    localparam logic [7:0] RSS_OUTPUT_RST = 8'h03;
    localparam logic [7:0] RSS_BACKUP_MASK = 8'h33;

    // Unlock key: arbitrary value chosen for this block.
    localparam logic [7:0] RSS_UNLOCK_KEY = 8'h7d;

    // Field positions.
    localparam int RSS_BA_LSB = 0;
    localparam int RSS_BB_LSB = 4;
    localparam int RSS_HI_LSB = 4;
    localparam int RSS_LO_LSB = 0;

    // Slot code ranges.
    localparam logic [3:0] RSS_SLOT_MIN = 4'h3;
    localparam logic [3:0] RSS_SLOT_MAX = 4'ha;
    localparam logic [1:0] RSS_BSLOT_ONE = 2'h1;
    localparam logic [1:0] RSS_BSLOT_TWO = 2'h2;

    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic req;
    } rss_bus_req_t;

    // One entry per sequenced item: bit n set means the item acts in slot n.
    typedef struct packed {
        logic [10:0] backup_a;
        logic [10:0] backup_b;
        logic [10:0] load_switch;
        logic [10:0] linear_reg;
        logic [10:0] output_one;
        logic [10:0] output_three;
    } rss_slot_map_t;

    typedef enum logic [1:0] {
        RSS_BUS_IDLE = 2'b01,
        RSS_BUS_ACK = 2'b10
    } rss_bus_state_t;

endpackage

// ---- rss_slot_config.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Backup A field: 1h is slot 1, 2h slot 2, 0h and 3h unsequenced.
// RQ2 - Slots 1 and 2 run only while the freshness seal flag reads zero.
// RQ3 - After the seal breaks, the backup converters are never switched off.
// RQ4 - A four-bit field maps 3h..Ah to slots 3..10; other codes skip.
// RQ5 - 0x25 holds switch 7-4 (6h) and regulator 3-0 (3h), resets to 0x63.
// RQ6 - 0x26 holds output three 7-4 (0h), output one 3-0 (3h), reset 0x03.
// RQ7 - Software ignores the seal flag while the backup supplies are off.
// RQ8 - Backup B field is bits 5-4, resets to 1h, coded as the A field.
// RQ9 - A slot register takes a write only right after the unlock key.
module rss_slot_config
    import rss_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic freshness_seal_flag,
    input wire logic [10:0] slot_strobe,
    input wire logic power_down,
    output logic [10:0] backup_a_on_slot,
    output logic [10:0] backup_b_on_slot,
    output logic [10:0] load_switch_on_slot,
    output logic [10:0] linear_reg_on_slot,
    output logic [10:0] output_one_on_slot,
    output logic [10:0] output_three_on_slot,
    output logic [5:0] rail_enable
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] wide_slot(input logic [3:0] code);
        logic [10:0] hot;
        hot = '0;
        if (code >= RSS_SLOT_MIN && code <= RSS_SLOT_MAX) begin // RQ4
            hot[code] = 1'b1;
        end
        return hot;
    endfunction

    function automatic logic [10:0] backup_slot(input logic [1:0] code,
                                                input logic seal);
        logic [10:0] hot;
        hot = '0;
        // A broken seal masks slots 1 and 2 entirely.
        if (!seal && (code == RSS_BSLOT_ONE || code == RSS_BSLOT_TWO)) begin
            hot[code] = 1'b1; // RQ1 RQ2
        end
        return hot;
    endfunction

    // Unmapped and write-only addresses read as zero, so software can probe
    // the map without side effects.
    function automatic logic [31:0] read_word(input logic [7:0] adr,
                                              input logic [7:0] bkp,
                                              input logic [7:0] swt,
                                              input logic [7:0] outp,
                                              input logic seal,
                                              input logic armed);
        logic [31:0] word;
        word = '0;
        case (adr)
            RSS_BACKUP_OFS: word[7:0] = bkp;
            RSS_SWITCH_OFS: word[7:0] = swt;
            RSS_OUTPUT_OFS: word[7:0] = outp;
            RSS_STATUS_OFS: word[1:0] = {seal, armed};
            default: word = '0;
        endcase
        return word;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    rss_bus_req_t req;
    rss_bus_state_t bus_reg, bus_next;
    logic [7:0] backup_reg, backup_next;
    logic [7:0] switch_reg, switch_next;
    logic [7:0] output_reg, output_next;
    logic unlock_reg, unlock_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic wr_ok;

    assign req.adr = wb_adr_i;
    assign req.dat = wb_dat_i;
    assign req.sel = wb_sel_i;
    assign req.we = wb_we_i;
    assign req.req = wb_cyc_i & wb_stb_i;

    // A write lands only on the single ack edge, which is one cycle after
    // the request is seen, so each access acts exactly once.
    always_comb begin
        bus_next = bus_reg;
        ack_next = 1'b0;
        rdat_next = rdat_reg;
        backup_next = backup_reg;
        switch_next = switch_reg;
        output_next = output_reg;
        unlock_next = unlock_reg;
        // Only the low byte lane carries a register, so sel[0] gates a write.
        wr_ok = req.req && req.we && req.sel[0];
        case (bus_reg)
            RSS_BUS_IDLE: begin
                if (req.req) begin
                    bus_next = RSS_BUS_ACK;
                    ack_next = 1'b1;
                    rdat_next = read_word(req.adr, backup_reg, switch_reg,
                                          output_reg, freshness_seal_flag,
                                          unlock_reg);
                end
            end
            RSS_BUS_ACK: begin
                bus_next = RSS_BUS_IDLE;
                if (wr_ok) begin
                    // Any write other than the key closes the unlock window,
                    // so a stray write between key and target costs the
                    // master a fresh key; one flag keeps the guard simple.
                    unlock_next = (req.adr == RSS_UNLOCK_OFS)
                        && (req.dat[7:0] == RSS_UNLOCK_KEY); // RQ9
                    if (unlock_reg) begin // RQ9
                        case (req.adr)
                            RSS_BACKUP_OFS:
                                backup_next = req.dat[7:0]
                                    & RSS_BACKUP_MASK; // RQ8
                            RSS_SWITCH_OFS: switch_next = req.dat[7:0]; // RQ5
                            RSS_OUTPUT_OFS: output_next = req.dat[7:0]; // RQ6
                            default: ;
                        endcase
                    end
                end
            end
            default: bus_next = RSS_BUS_IDLE;
        endcase
    end

    // The read word is cleared in reset too, so the first read after reset
    // can never show stale data from before it.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bus_reg <= RSS_BUS_IDLE;
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            backup_reg <= RSS_BACKUP_RST; // RQ8
            switch_reg <= RSS_SWITCH_RST; // RQ5
            output_reg <= RSS_OUTPUT_RST; // RQ6
            unlock_reg <= 1'b0;
        end else begin
            bus_reg <= bus_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            backup_reg <= backup_next;
            switch_reg <= switch_next;
            output_reg <= output_next;
            unlock_reg <= unlock_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    ////////////////////////////////////////////////////////////////////////
    // Slot decode and rail enables.
    // The maps are registered so every output leaves a flip-flop; a field
    // change therefore reaches the slot maps one cycle after the write.
    rss_slot_map_t map_reg, map_next;
    logic [5:0] en_reg, en_next;

    always_comb begin
        map_next.backup_a = backup_slot(backup_reg[RSS_BA_LSB +: 2],
                                        freshness_seal_flag);
        map_next.backup_b = backup_slot(backup_reg[RSS_BB_LSB +: 2],
                                        freshness_seal_flag); // RQ8
        map_next.load_switch = wide_slot(switch_reg[RSS_HI_LSB +: 4]); // RQ5
        map_next.linear_reg = wide_slot(switch_reg[RSS_LO_LSB +: 4]);
        map_next.output_three = wide_slot(output_reg[RSS_HI_LSB +: 4]); // RQ6
        map_next.output_one = wide_slot(output_reg[RSS_LO_LSB +: 4]);
        // Enables move only on a strobe, so a field rewritten mid-sequence
        // affects only the slots still to come.
        en_next = en_reg;
        if (power_down) begin
            // Items release on their slot in the falling sequence; the
            // backup pair stays on once the seal is broken.
            if (|(map_reg.output_three & slot_strobe)) en_next[5] = 1'b0;
            if (|(map_reg.output_one & slot_strobe)) en_next[4] = 1'b0;
            if (|(map_reg.linear_reg & slot_strobe)) en_next[3] = 1'b0;
            if (|(map_reg.load_switch & slot_strobe)) en_next[2] = 1'b0;
            if (!freshness_seal_flag) begin // RQ3
                if (|(map_reg.backup_b & slot_strobe)) en_next[1] = 1'b0;
                if (|(map_reg.backup_a & slot_strobe)) en_next[0] = 1'b0;
            end
        end else begin
            if (|(map_reg.output_three & slot_strobe)) en_next[5] = 1'b1;
            if (|(map_reg.output_one & slot_strobe)) en_next[4] = 1'b1;
            if (|(map_reg.linear_reg & slot_strobe)) en_next[3] = 1'b1;
            if (|(map_reg.load_switch & slot_strobe)) en_next[2] = 1'b1;
            if (|(map_reg.backup_b & slot_strobe)) en_next[1] = 1'b1; // RQ2
            if (|(map_reg.backup_a & slot_strobe)) en_next[0] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            map_reg <= '0;
            en_reg <= '0;
        end else begin
            map_reg <= map_next;
            en_reg <= en_next;
        end
    end

    assign backup_a_on_slot = map_reg.backup_a;
    assign backup_b_on_slot = map_reg.backup_b;
    assign load_switch_on_slot = map_reg.load_switch;
    assign linear_reg_on_slot = map_reg.linear_reg;
    assign output_one_on_slot = map_reg.output_one;
    assign output_three_on_slot = map_reg.output_three;
    assign rail_enable = en_reg;

endmodule

// ---- rss_slot_config_sva.sv ----
`timescale 1ns/1ps
module rss_slot_config_sva
    import rss_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic freshness_seal_flag,
    input wire logic [10:0] slot_strobe,
    input wire logic power_down,
    input wire logic [10:0] backup_a_on_slot,
    input wire logic [10:0] load_switch_on_slot,
    input wire logic [5:0] rail_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_seal_skip: assert property (
        freshness_seal_flag && $past(freshness_seal_flag)
        |-> backup_a_on_slot == 11'h0) else $error("early slot with seal");
    chk_backup_kept: assert property (
        freshness_seal_flag && power_down |=> (rail_enable[1:0] &
        $past(rail_enable[1:0])) == $past(rail_enable[1:0]))
        else $error("backup rail turned off after seal");
    chk_backup_code: assert property (
        backup_a_on_slot[10:3] == 8'h0 && !backup_a_on_slot[0])
        else $error("backup slot outside one and two");
    chk_field_range: assert property (
        $onehot0(load_switch_on_slot) && load_switch_on_slot[2:0] == 3'h0)
        else $error("switch slot outside three to ten");
    chk_rail_up: assert property (
        !power_down && |(slot_strobe & load_switch_on_slot) |=> rail_enable[2])
        else $error("switch not enabled at its slot");
    chk_rail_down: assert property (
        power_down && |(slot_strobe & load_switch_on_slot) |=> !rail_enable[2])
        else $error("switch not disabled at its slot");
endmodule
bind rss_slot_config rss_slot_config_sva u_chk (.clock(clock),
    .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .freshness_seal_flag(freshness_seal_flag), .slot_strobe(slot_strobe),
    .power_down(power_down), .backup_a_on_slot(backup_a_on_slot),
    .load_switch_on_slot(load_switch_on_slot), .rail_enable(rail_enable));

// ---- tb_rss_slot_config.sv ----
`timescale 1ns/1ps
module tb_rss_slot_config
    import rss_pkg::*;
;
    logic clock, rst_b, cyc, stb, we, seal, pd, ack;
    logic [7:0] adr;
    logic [31:0] wdat, rd, dat_o;
    logic [10:0] strobe, ma, mb, ml, mr, m1, m3;
    logic [5:0] en;
    logic [3:0] k;
    int n_fail, total_checks, cyc_count;
    rss_slot_config u_rss_slot_config (.clock(clock), .rst_b(rst_b),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .freshness_seal_flag(seal), .slot_strobe(strobe), .power_down(pd),
        .backup_a_on_slot(ma), .backup_b_on_slot(mb),
        .load_switch_on_slot(ml), .linear_reg_on_slot(mr),
        .output_one_on_slot(m1), .output_three_on_slot(m3),
        .rail_enable(en));
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        if (n_fail == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // The request stays up until ack is seen, so slow answers are safe.
    task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clock);
        adr <= a; we <= w; wdat <= {24'h0, d}; cyc <= 1; stb <= 1;
        do @(posedge clock); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 0; stb <= 0;
    endtask
    task prog(input logic [7:0] a, input logic [7:0] d);
        xfer(RSS_UNLOCK_OFS, 1, RSS_UNLOCK_KEY);
        xfer(a, 1, d);
    endtask
    task pulse(input int n);
        @(posedge clock) strobe <= 11'h1 << n;
        @(posedge clock) strobe <= 11'h0;
        @(negedge clock);
    endtask
    function logic [10:0] d4(input logic [3:0] c);
        d4 = (c >= 4'h3 && c <= 4'ha) ? 11'h1 << c : 11'h0;
    endfunction
    function logic [10:0] d2(input logic [1:0] c);
        d2 = (c == 2'h1 || c == 2'h2) ? 11'h1 << c : 11'h0;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc_count++;
        if (cyc_count == 5000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        {cyc, stb, we, seal, pd, rst_b} = 6'h0;
        adr = 8'h0; wdat = 32'h0; strobe = 11'h0;
        repeat (3) @(posedge clock);
        rst_b <= 1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("map sw", ml, 11'h040);
        check("map lr", mr, 11'h008);
        check("map o1", m1, 11'h008);
        check("map o3", m3, 11'h000);
        check("map a", ma, 11'h004);
        check("map b", mb, 11'h002);
        xfer(RSS_BACKUP_OFS, 0, 0); check("rst 24", rd, 32'h12);
        xfer(RSS_SWITCH_OFS, 0, 0); check("rst 25", rd, 32'h63);
        xfer(RSS_OUTPUT_OFS, 0, 0); check("rst 26", rd, 32'h03);
        // A write without the key just before it must be dropped.
        xfer(RSS_SWITCH_OFS, 1, 8'h00);
        xfer(RSS_SWITCH_OFS, 0, 0); check("locked", rd, 32'h63);
        xfer(8'h30, 0, 0); check("unmapped", rd, 32'h0);
        for (int c = 0; c < 16; c++) begin
            k = c[3:0];
            prog(RSS_SWITCH_OFS, {k, ~k});
            prog(RSS_OUTPUT_OFS, {~k, k});
            prog(RSS_BACKUP_OFS, {2'h3, k[1:0], 2'h3, k[3:2]});
            repeat (2) @(posedge clock);
            @(negedge clock);
            check("sw", ml, d4(k));
            check("lr", mr, d4(~k));
            check("o3", m3, d4(~k));
            check("o1", m1, d4(k));
            check("a", ma, d2(k[3:2]));
            check("b", mb, d2(k[1:0]));
            xfer(RSS_BACKUP_OFS, 0, 0);
            check("rd 24", rd, {26'h0, k[1:0], 2'h0, k[3:2]});
        end
        prog(RSS_SWITCH_OFS, 8'h45);
        prog(RSS_BACKUP_OFS, 8'h21);
        prog(RSS_OUTPUT_OFS, 8'h97);
        pulse(4); check("sw up", en[3:2], 2'b01);
        pulse(1); check("a up", en[0], 1'b1);
        pulse(2); check("b up", en[1], 1'b1);
        pulse(5); check("lr up", en[3], 1'b1);
        pulse(7); check("o1 up", en[4], 1'b1);
        pulse(9); check("o3 up", en[5], 1'b1);
        @(posedge clock) seal <= 1;
        pd <= 1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check("seal a", ma, 11'h0);
        check("seal b", mb, 11'h0);
        xfer(RSS_STATUS_OFS, 0, 0); check("status", rd[1], 1'b1);
        pulse(1);
        pulse(2);
        pulse(4); check("down", en[2:0], 3'b011);
        pulse(5); check("lr down", en[3], 1'b0);
        complete_run;
    end
endmodule
